// File: design/eew_core.v
// Serial EEPROM target with lower-half write protection
`timescale 1ns/100ps
`include "eew_regs.vh"

// Operation
// RULE_01 - Only lower 128 bytes protectable, by command
// RULE_02 - Protection state survives power loss
// RULE_03 - Group 1010b selects array, straps compared
// RULE_04 - Group 0110b selects protection commands
// RULE_05 - Address bytes arrive most significant first
// RULE_06 - Respond only on full seven-bit match
// RULE_07 - Permanent commands compare straps against pins
// RULE_08 - Overvoltage plus bits 3,2 pick reversible commands
// RULE_09 - Host applies overvoltage and strap levels
// RULE_10 - Direction bit zero sets, one reads
// RULE_11 - Acknowledge in ninth bit on match
// RULE_12 - No acknowledge on mismatch or locked commands
// RULE_13 - Permanent lock is final, hides group 0110b
// RULE_14 - Lock commands are byte writes, contents ignored
// RULE_15 - Protected lower writes: data nacked, no cycle
// RULE_16 - Reversibly locked: lock nacked, others program
// RULE_17 - Unprotected: locks program, clear only acked
// RULE_18 - Protection reads use direction bit one
// RULE_19 - Protection reads ack per state, then nack
// RULE_20 - Counter points past last byte, wraps
// RULE_21 - Array read acks then sends counter byte
// RULE_22 - Host ends read with nack and stop
// RULE_23 - Selective read via dummy write, repeated start
// RULE_24 - Sequential read continues while host acks
// RULE_25 - Programming starts after stop, requests ignored
// RULE_26 - Address not acknowledged while programming
// RULE_27 - Overvoltage arrives as flag, replaces low strap
// RULE_28 - Programming time is parameter, busy throughout
module eew_core #(
  parameter [31:0] PROG_CYCLES = `EEW_PROG_CYCLES, // Write cycle length
  parameter PAGE_BITS = 4 // Log2 of page size
) (
  clk,
  rst,
  scl_in,
  sda_in,
  sda_out,
  sda_oe,
  strap_bit_high,
  strap_bit_mid,
  strap_bit_low,
  overvoltage_level,
  busy,
  perm_locked,
  rev_locked
);
  input wire clk; // System clock
  input wire rst; // Synchronous reset, active high
  input wire scl_in; // Bus clock pin level
  input wire sda_in; // Bus data pin level
  output wire sda_out; // Open-drain data, only ever low
  output reg sda_oe; // High while pulling data low
  input wire strap_bit_high; // Strap pin, address bit 3
  input wire strap_bit_mid; // Strap pin, address bit 2
  input wire strap_bit_low; // Strap pin, address bit 1
  input wire overvoltage_level; // Detector flag for lowest strap
  output wire busy; // Internal programming in progress
  output reg perm_locked; // Permanent protection set
  output reg rev_locked; // Reversible protection set

  localparam PAGE = 1 << PAGE_BITS;

  // Synchroniser stages; stage one feeds only stage two
  reg scl_s1, scl_s2, scl_d;
  reg sda_s1, sda_s2, sda_d;
  reg [2:0] strap_s1, strap_s2;
  reg ov_s1, ov_s2;

  // Bus engine state
  reg [3:0] state; // Current bus phase
  reg [3:0] bit_cnt; // Bits seen in current byte
  reg [7:0] shreg; // Received byte
  reg [7:0] tx_sh; // Byte being sent
  reg [2:0] cmd_kind; // Kind of current transaction
  reg cmd_rw; // Direction bit of current address
  reg host_ack; // Host acked last sent byte
  reg [7:0] addr_cnt; // Internal address counter
  reg [2:0] pend_kind; // Job to start at stop

  // Page buffer waiting for the programming cycle
  reg [7:0] page_buf [0:PAGE-1];
  reg [PAGE-1:0] page_mask; // Which buffer bytes are loaded
  reg [7-PAGE_BITS:0] page_sel; // Page being written
  reg [7-PAGE_BITS:0] commit_page; // Page under programming
  reg [PAGE_BITS:0] commit_idx; // Buffer byte being committed
  reg [PAGE-1:0] commit_mask; // Snapshot of loaded bytes
  reg [31:0] busy_cnt; // Cycles left of programming

  // Storage array, kept without reset as a non-volatile cell would
  reg [7:0] mem [0:255];
  integer i;

  // Power-on contents of the non-volatile cells
  initial begin
    for (i = 0; i < 256; i = i + 1) begin
      mem[i] = 8'hff;
    end
    perm_locked = 1'b0; // [RULE_02]
    rev_locked = 1'b0; // [RULE_02]
  end

  // Edge and condition detection on the synchronised bus
  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;
  wire byte_done = (bit_cnt == 4'h8);
  wire lower_locked = perm_locked | rev_locked;

  assign sda_out = 1'b0;
  assign busy = (busy_cnt != 32'h0); // [RULE_28]

  // Two-stage synchronisers for all pins and the detector flag
  always @(posedge clk) begin
    if (rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
      ov_s1 <= 1'b0;
      ov_s2 <= 1'b0;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      strap_s1 <= {strap_bit_high, strap_bit_mid, strap_bit_low};
      strap_s2 <= strap_s1;
      ov_s1 <= overvoltage_level; // [RULE_27]
      ov_s2 <= ov_s1;
    end
  end

  // Address byte decode and acknowledge decision
  reg [2:0] dec_kind;
  reg dec_ack;
  always @* begin
    dec_kind = `EEW_K_NONE;
    dec_ack = 1'b0;
    // Fixed group sits in the first four bits shifted in [RULE_05]
    if (shreg[7:4] == `EEW_GRP_ARRAY && shreg[3:1] == strap_s2) begin
      dec_kind = `EEW_K_ARRAY; // [RULE_03] [RULE_06]
    end else if (shreg[7:4] == `EEW_GRP_PROT) begin // [RULE_04]
      if (ov_s2) begin
        // Flag stands in for the low strap compare [RULE_27]
        if (shreg[3:2] == `EEW_OV_LOCK) begin
          dec_kind = `EEW_K_RLOCK; // [RULE_08]
        end else if (shreg[3:2] == `EEW_OV_UNLOCK) begin
          dec_kind = `EEW_K_RCLR; // [RULE_08]
        end
      end else if (shreg[3:1] == strap_s2) begin
        dec_kind = `EEW_K_PERM; // [RULE_07]
      end
    end
    case (dec_kind)
      `EEW_K_ARRAY: dec_ack = 1'b1; // [RULE_11]
      // Permanent lock hides every protection command [RULE_13]
      `EEW_K_PERM: dec_ack = ~perm_locked; // [RULE_12] [RULE_17]
      // Repeat lock and its query refused when locked [RULE_16]
      `EEW_K_RLOCK: dec_ack = ~perm_locked & ~rev_locked; // [RULE_19]
      `EEW_K_RCLR: dec_ack = ~perm_locked; // [RULE_19]
      default: dec_ack = 1'b0; // Mismatch: bus left alone [RULE_06]
    endcase
    // No answer at all while programming [RULE_26]
    if (busy) begin
      dec_ack = 1'b0;
    end
  end

  // Bus engine: receive, acknowledge, transmit
  always @(posedge clk) begin
    if (rst) begin
      state <= `EEW_S_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx_sh <= 8'h00;
      cmd_kind <= `EEW_K_NONE;
      cmd_rw <= 1'b0;
      host_ack <= 1'b0;
      addr_cnt <= 8'h00;
      pend_kind <= `EEW_K_NONE;
      page_mask <= {PAGE{1'b0}};
      page_sel <= {(8-PAGE_BITS){1'b0}};
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      // Start or repeated start: fresh address byte [RULE_23]
      state <= `EEW_S_ADDR;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      // Stop ends everything; programming hand-off is elsewhere
      state <= `EEW_S_IDLE;
      sda_oe <= 1'b0;
      pend_kind <= `EEW_K_NONE; // [RULE_25]
    end else if (scl_rise) begin
      case (state)
        `EEW_S_ADDR, `EEW_S_WORD, `EEW_S_DATA: begin
          shreg <= {shreg[6:0], sda_s2}; // MSB first [RULE_05]
          bit_cnt <= bit_cnt + 4'h1;
        end
        `EEW_S_TX: begin
          bit_cnt <= bit_cnt + 4'h1;
        end
        `EEW_S_TX_ACK: begin
          host_ack <= ~sda_s2; // [RULE_22]
        end
        default: begin
          bit_cnt <= bit_cnt;
        end
      endcase
    end else if (scl_fall) begin
      case (state)
        `EEW_S_ADDR: begin
          if (byte_done) begin
            cmd_kind <= dec_kind;
            cmd_rw <= shreg[0]; // [RULE_10] [RULE_18]
            if (dec_ack) begin
              sda_oe <= 1'b1; // Ninth bit acknowledge [RULE_11]
              state <= `EEW_S_ADDR_ACK;
            end else begin
              state <= `EEW_S_IDLE; // [RULE_12]
            end
          end
        end
        `EEW_S_ADDR_ACK: begin
          bit_cnt <= 4'h0;
          if (cmd_kind == `EEW_K_ARRAY && cmd_rw) begin
            // Send the byte at the counter [RULE_21]
            tx_sh <= mem[addr_cnt];
            sda_oe <= ~mem[addr_cnt][7];
            addr_cnt <= addr_cnt + 8'h01; // [RULE_20]
            state <= `EEW_S_TX;
          end else begin
            sda_oe <= 1'b0;
            state <= `EEW_S_WORD;
          end
        end
        `EEW_S_WORD: begin
          if (byte_done) begin
            if (cmd_kind == `EEW_K_ARRAY) begin
              // Byte address sets the counter and the page [RULE_23]
              addr_cnt <= shreg;
              page_sel <= shreg[7:PAGE_BITS];
              page_mask <= {PAGE{1'b0}};
              sda_oe <= 1'b1;
              state <= `EEW_S_WORD_ACK;
            end else if (!cmd_rw) begin
              sda_oe <= 1'b1; // Content ignored [RULE_14]
              state <= `EEW_S_WORD_ACK;
            end else begin
              state <= `EEW_S_IDLE; // Query: no more acks [RULE_19]
            end
          end
        end
        `EEW_S_WORD_ACK, `EEW_S_DATA_ACK: begin
          sda_oe <= 1'b0;
          bit_cnt <= 4'h0;
          // Protection commands take a single data byte
          if (state == `EEW_S_DATA_ACK && cmd_kind != `EEW_K_ARRAY) begin
            state <= `EEW_S_IDLE;
          end else begin
            state <= `EEW_S_DATA;
          end
        end
        `EEW_S_DATA: begin
          if (byte_done) begin
            if (cmd_kind == `EEW_K_ARRAY) begin
              if (lower_locked && !addr_cnt[`EEW_PROT_BIT]) begin
                state <= `EEW_S_IDLE; // Data nacked [RULE_01] [RULE_15]
              end else begin
                // Page wrap keeps later bytes over earlier ones
                page_buf[addr_cnt[PAGE_BITS-1:0]] <= shreg;
                page_mask[addr_cnt[PAGE_BITS-1:0]] <= 1'b1;
                addr_cnt[PAGE_BITS-1:0] <=
                  addr_cnt[PAGE_BITS-1:0] + {{(PAGE_BITS-1){1'b0}}, 1'b1};
                pend_kind <= `EEW_K_ARRAY; // [RULE_17]
                sda_oe <= 1'b1;
                state <= `EEW_S_DATA_ACK;
              end
            end else begin
              sda_oe <= 1'b1; // Data content ignored [RULE_14]
              state <= `EEW_S_DATA_ACK;
              // Clear when unprotected is acked only [RULE_17]
              if (cmd_kind != `EEW_K_RCLR || rev_locked) begin
                pend_kind <= cmd_kind; // [RULE_16]
              end
            end
          end
        end
        `EEW_S_TX: begin
          if (byte_done) begin
            sda_oe <= 1'b0; // Release for host answer
            host_ack <= 1'b0;
            state <= `EEW_S_TX_ACK;
          end else begin
            tx_sh <= {tx_sh[6:0], 1'b0};
            sda_oe <= ~tx_sh[6];
          end
        end
        `EEW_S_TX_ACK: begin
          bit_cnt <= 4'h0;
          if (host_ack) begin
            // Keep streaming, counter wraps at the top [RULE_24]
            tx_sh <= mem[addr_cnt];
            sda_oe <= ~mem[addr_cnt][7];
            addr_cnt <= addr_cnt + 8'h01; // [RULE_20]
            state <= `EEW_S_TX;
          end else begin
            state <= `EEW_S_IDLE; // Host nack ends read [RULE_22]
          end
        end
        default: begin
          state <= `EEW_S_IDLE;
        end
      endcase
    end
  end

  // Programming cycle: starts at stop, holds busy for its length
  always @(posedge clk) begin
    if (rst) begin
      busy_cnt <= 32'h0;
      commit_idx <= {(PAGE_BITS+1){1'b1}};
      commit_page <= {(8-PAGE_BITS){1'b0}};
      commit_mask <= {PAGE{1'b0}};
    end else if (bus_stop && pend_kind != `EEW_K_NONE && !busy) begin
      busy_cnt <= PROG_CYCLES; // [RULE_25] [RULE_28]
      commit_idx <= {(PAGE_BITS+1){1'b0}};
      commit_page <= page_sel;
      // Only array jobs touch the storage
      commit_mask <= (pend_kind == `EEW_K_ARRAY) ? page_mask : {PAGE{1'b0}};
    end else if (busy) begin
      busy_cnt <= busy_cnt - 32'h1;
      if (!commit_idx[PAGE_BITS]) begin
        commit_idx <= commit_idx + {{PAGE_BITS{1'b0}}, 1'b1};
      end
    end
  end

  // Commit buffered page bytes one per cycle during the cycle
  always @(posedge clk) begin
    if (busy && !commit_idx[PAGE_BITS] &&
        commit_mask[commit_idx[PAGE_BITS-1:0]]) begin
      mem[{commit_page, commit_idx[PAGE_BITS-1:0]}] <=
        page_buf[commit_idx[PAGE_BITS-1:0]];
    end
  end

  // Protection state: non-volatile, so reset leaves it alone
  always @(posedge clk) begin
    if (bus_stop && !busy && !rst) begin
      case (pend_kind)
        `EEW_K_PERM: perm_locked <= 1'b1; // Never cleared [RULE_13]
        `EEW_K_RLOCK: rev_locked <= 1'b1; // [RULE_17]
        `EEW_K_RCLR: rev_locked <= 1'b0; // [RULE_16]
        default: perm_locked <= perm_locked;
      endcase
    end
  end

endmodule

// File: design/eew_regs.vh
// Constants for the serial EEPROM write-protect block
`ifndef EEW_REGS_VH
`define EEW_REGS_VH

// Fixed four-bit groups of the address byte
`define EEW_GRP_ARRAY 4'ha
`define EEW_GRP_PROT 4'h6

// Protected region: bytes below this bit of the byte address
`define EEW_PROT_BIT 7

// Strap code of bits 3..2 for the overvoltage commands
`define EEW_OV_LOCK 2'h0
`define EEW_OV_UNLOCK 2'h1

// Command kinds, also used for the pending programming job
`define EEW_K_NONE 3'h0
`define EEW_K_ARRAY 3'h1
`define EEW_K_PERM 3'h2
`define EEW_K_RLOCK 3'h3
`define EEW_K_RCLR 3'h4

// Bus FSM states
`define EEW_S_IDLE 4'h0
`define EEW_S_ADDR 4'h1
`define EEW_S_ADDR_ACK 4'h2
`define EEW_S_WORD 4'h3
`define EEW_S_WORD_ACK 4'h4
`define EEW_S_DATA 4'h5
`define EEW_S_DATA_ACK 4'h6
`define EEW_S_TX 4'h7
`define EEW_S_TX_ACK 4'h8

// Timing: internal programming time and system clock period
`define EEW_PROG_TIME_NS 5000000
`define EEW_CLK_PERIOD_NS 8
`define EEW_PROG_CYCLES \
  ((`EEW_PROG_TIME_NS + `EEW_CLK_PERIOD_NS - 1) / `EEW_CLK_PERIOD_NS)

`endif

// File: verif/eew_core_assertions.sv
// Port checker for the write-protect EEPROM target
`timescale 1ns/100ps
module eew_core_chk #(
  parameter [31:0] PROG_CYCLES = 50
) (
  input logic clk,
  input logic rst,
  input logic scl_in,
  input logic sda_in,
  input logic sda_out,
  input logic sda_oe,
  input logic busy,
  input logic perm_locked,
  input logic rev_locked
);
  logic [31:0] busy_cnt; // Cycles busy has stood high
  // Count busy cycles; a counter avoids a huge repetition
  always @(posedge clk) begin
    if (rst || !busy) begin
      busy_cnt <= 32'h0;
    end else begin
      busy_cnt <= busy_cnt + 32'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_data_never_high: assert property (sda_out == 1'b0)
    else $error("data driven high");
  a_ack_rise_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("drive started with clock high");
  a_release_clk_low: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("drive released with clock high");
  a_busy_full_len: assert property (
    $fell(busy) |-> busy_cnt == PROG_CYCLES)
    else $error("write cycle length wrong");
  a_busy_no_ack: assert property (busy |-> !sda_oe)
    else $error("answered while programming");
  a_perm_final: assert property (perm_locked |=> perm_locked)
    else $error("permanent lock cleared");
  a_perm_programs: assert property (
    $rose(perm_locked) |-> ##[0:3] busy)
    else $error("lock set without write cycle");
  a_rev_programs: assert property (
    $changed(rev_locked) |-> ##[0:3] busy)
    else $error("reversible change without write cycle");
  a_prog_after_stop: assert property (
    $rose(busy) |-> scl_in && sda_in)
    else $error("write cycle began outside stop");
endmodule
bind eew_core eew_core_chk #(.PROG_CYCLES(PROG_CYCLES)) i_eew_core_chk(
  .clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .busy(busy), .perm_locked(perm_locked),
  .rev_locked(rev_locked));

// File: verif/eew_core_test.sv
// Self-checking bench for the write-protect EEPROM target
`timescale 1ns/100ps
`include "eew_regs.vh"
module eew_core_test;
  localparam int PC = 400; // Short write cycle, longer than one byte
  logic clk, rst, scl, sda_low, ov, busy, sda_oe, sda_out, a;
  logic perm_locked, rev_locked;
  logic [2:0] strap, pins; // Board straps and present pin levels
  logic [7:0] d, w;
  logic [7:0] mem [256]; // Expected array contents
  int mismatches, total_checks, st; // st: 0 open, 1 reversible, 2 permanent
  int ops [15] = '{3, 2, 1, 3, 4, 1, 2, 1, 0, 3, 0, 1, 2, 4, 5};
  wire sda = !(sda_low || sda_oe); // Pull-up resolves the wire
  eew_host i_eew_host(.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  eew_core #(.PROG_CYCLES(PC)) i_eew_core(.clk(clk), .rst(rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .strap_bit_high(pins[2]), .strap_bit_mid(pins[1]),
    .strap_bit_low(pins[0]), .overvoltage_level(ov), .busy(busy),
    .perm_locked(perm_locked), .rev_locked(rev_locked));
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask
  // Verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Bounded wait for the write cycle to end
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    #1;
    if (n >= 2000) begin
      mismatches++;
      $display("Error at %0t: busy %h expected %h", $time, busy, 1'b0);
      results;
    end
  endtask
  // Single byte write; lower half refused while protected
  task automatic wr(input logic [7:0] wa, input logic [7:0] v);
    logic e;
    e = (st == 0) || wa[7];
    i_eew_host.start;
    i_eew_host.send({`EEW_GRP_ARRAY, strap, 1'b0}, a);
    chk1(a, 1'b1);
    i_eew_host.send(wa, a);
    chk1(a, 1'b1);
    i_eew_host.send(v, a);
    chk1(a, e);
    i_eew_host.stop;
    chk1(busy, e);
    wait_idle;
    if (e) mem[wa] = v;
  endtask
  // Selective sequential read of n bytes, then a current-address read
  task automatic rd(input logic [7:0] wa, input int n);
    i_eew_host.start;
    i_eew_host.send({`EEW_GRP_ARRAY, strap, 1'b0}, a);
    i_eew_host.send(wa, a);
    i_eew_host.start;
    i_eew_host.send({`EEW_GRP_ARRAY, strap, 1'b1}, a);
    chk1(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_eew_host.recv(i < n - 1, d);
      chk(d, mem[8'(wa + i)]);
    end
    i_eew_host.stop;
    i_eew_host.start;
    i_eew_host.send({`EEW_GRP_ARRAY, strap, 1'b1}, a);
    i_eew_host.recv(1'b0, d);
    chk(d, mem[8'(wa + n)]);
    i_eew_host.stop;
  endtask
  // Protection command k: 0 permanent, 1 reversible lock, 2 clear
  task automatic prot(input int k, input logic rw);
    logic [2:0] c;
    logic e, cy;
    c = (k == 0) ? strap : (k == 1) ? 3'b000 : 3'b010;
    pins = c;
    ov = (k != 0);
    e = (st == 0) || (st == 1 && k != 1);
    cy = !rw && e && !(st == 0 && k == 2);
    i_eew_host.start;
    i_eew_host.send({`EEW_GRP_PROT, c, rw}, a);
    chk1(a, e);
    i_eew_host.send(8'($urandom), a);
    chk1(a, e && !rw);
    i_eew_host.send(8'($urandom), a);
    chk1(a, e && !rw);
    i_eew_host.stop;
    chk1(busy, cy);
    wait_idle;
    pins = strap;
    ov = 1'b0;
    if (cy) st = (k == 0) ? 2 : (k == 1) ? 1 : 0;
    chk1(perm_locked, st == 2);
    if (st != 2) chk1(rev_locked, st == 1);
  endtask
  // System clock, 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    ov = 1'b0;
    mismatches = 0;
    total_checks = 0;
    st = 0;
    foreach (mem[i]) mem[i] = 8'hff;
    void'($urandom(69265));
    strap = 3'($urandom);
    pins = strap;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    // Wrong strap bits or wrong fixed group are ignored
    for (int j = 0; j < 5; j++) begin
      i_eew_host.start;
      if (j < 3) begin
        w = {`EEW_GRP_ARRAY, strap ^ (3'h1 << j), 1'b1};
      end else if (j == 3) begin
        w = {4'h2, strap, 1'b1};
      end else begin
        // Protection group, strap bit 3 wrong, no overvoltage
        w = {`EEW_GRP_PROT, strap ^ 3'h4, 1'b1};
      end
      i_eew_host.send(w, a);
      chk1(a, 1'b0);
      i_eew_host.stop;
    end
    $display("test address match done");
    // Poll during the write cycle: address refused
    i_eew_host.start;
    i_eew_host.send({`EEW_GRP_ARRAY, strap, 1'b0}, a);
    i_eew_host.send(8'hfe, a);
    i_eew_host.send(8'h5a, a);
    i_eew_host.stop;
    i_eew_host.start;
    i_eew_host.send({`EEW_GRP_ARRAY, strap, 1'b1}, a);
    chk1(a, 1'b0);
    i_eew_host.stop;
    wait_idle;
    mem[8'hfe] = 8'h5a;
    wr(8'h00, 8'($urandom));
    rd(8'hfe, 4);
    for (int j = 0; j < 6; j++) begin
      w = 8'($urandom);
      wr(w, 8'($urandom));
      rd(w, 2);
    end
    $display("test array access done");
    // Protection states walked through a table of operations
    foreach (ops[j]) begin
      if (ops[j] < 3) prot(ops[j], 1'b0);
      if (ops[j] == 3) for (int k = 0; k < 3; k++) prot(k, 1'b1);
      if (ops[j] > 3) begin
        w = {ops[j] == 5, 7'($urandom)};
        wr(w, 8'($urandom));
        rd(w, 1);
      end
    end
    $display("test protection done");
    // Lock state survives a reset
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk1(perm_locked, 1'b1);
    chk1(sda_out, 1'b0);
    wr(8'h10, 8'h3c);
    rd(8'h10, 1);
    $display("test persistence done");
    results;
  end
endmodule

// File: verif/eew_host.sv
// Host model for the two-wire link: clock and open-drain data
`timescale 1ns/100ps
module eew_host (
  input logic clk,
  input logic sda,
  output logic scl,
  output logic sda_low
);
  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Advance n system clocks, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One bit slot of 160 ns; data set mid-low, read mid-high
  task automatic bit_slot(input logic b, output logic r);
    tick(5);
    sda_low = !b;
    tick(5);
    scl = 1'b1;
    tick(5);
    r = sda;
    tick(5);
    scl = 1'b0;
  endtask
  // Start or repeated start: data falls while clock high
  task automatic start;
    tick(5);
    sda_low = 1'b0;
    tick(5);
    scl = 1'b1;
    tick(10);
    sda_low = 1'b1;
    tick(10);
    scl = 1'b0;
  endtask
  // Stop: data rises while clock high, clock then stands high
  task automatic stop;
    tick(5);
    sda_low = 1'b1;
    tick(5);
    scl = 1'b1;
    tick(10);
    sda_low = 1'b0;
    tick(20);
  endtask
  // Byte out, then sample the target's acknowledge
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(d[i], r);
    bit_slot(1'b1, r);
    ack = !r;
  endtask
  // Byte in; a nack here ends a read
  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, r);
      d[i] = r;
    end
    bit_slot(!ack, r);
  endtask
endmodule
